// >>> core/uvepc_host.sv
// Host controller that drives the memory pins for read, program, verify, id
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE_01: Memory drives data only when chip select and output gate both low.
// RULE_02: Output gate alone gates data; select low with gate high floats bus.
// RULE_03: Chip select high puts memory in standby, outputs float.
// RULE_04: Outputs float after whichever of gate or select rises first.
// RULE_05: Chip select is the per-device select; gate follows read strobe.
// RULE_06: Erased bits read 1; programming only clears bits presented as 0.
// RULE_07: No electrical operation turns a stored 0 back into 1.
// RULE_08: Programming needs high supply plus chip select and strobe both low.
// RULE_09: Programmer presents whole byte and address while programming.
// RULE_10: Select or strobe high inhibits programming despite high supply.
// RULE_11: Parallel parts share inputs except select; pulse select and strobe.
// RULE_12: Verify uses select and gate low, strobe high, supply high.
// RULE_13: Signature entry forces high voltage on address line nine.
// RULE_14: Signature byte chosen by address line zero, low then high.
// RULE_15: Other address lines are held low during signature readout.
// RULE_16: Line zero low gives maker byte, high gives type byte.
// RULE_17: Address and data stay stable through each strobe pulse.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module uvepc_host #(
  parameter int PULSE_CYCLES = uvepc_pkg::PULSE_CYC
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Request side
  input  wire logic                          reqValid,
  input  wire uvepc_pkg::uvepc_req_t         req,
  output logic                               reqReady,
  output logic                               rspValid,
  output logic [uvepc_pkg::DATA_W-1:0]       rspData,
  output logic                               rspMismatch,
  // Memory control pins
  output uvepc_pkg::uvepc_pins_t             pins,
  // Memory data pins
  input  wire logic [uvepc_pkg::DATA_W-1:0]  dataIn,
  output logic [uvepc_pkg::DATA_W-1:0]       dataOut,
  output logic                               dataOe
);
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_PULSE, S_ACCESS, S_FLOAT
  } uvepc_state_t;

  uvepc_state_t                      state_q, state_d;
  uvepc_pkg::uvepc_req_t             cur_q;
  logic                              timerLoad;
  logic [uvepc_pkg::CNT_W-1:0]       timerCount;
  logic                              timerDone;

  wire isProg = (cur_q.cmd == uvepc_pkg::UVEPC_CMD_PROG);
  wire isRead = (cur_q.cmd == uvepc_pkg::UVEPC_CMD_READ);
  wire isSig  = (cur_q.cmd == uvepc_pkg::UVEPC_CMD_SIG);
  wire accept = reqReady && reqValid;
  // Signature: only line zero follows request, others low
  wire [uvepc_pkg::ADDR_W-1:0] sigAddr = {
    {(uvepc_pkg::ADDR_W-1){1'b0}}, cur_q.addr[uvepc_pkg::SEL_LINE]}; // RULE_15
  wire [uvepc_pkg::ADDR_W-1:0] pinAddr = isSig ? sigAddr : cur_q.addr;
  wire readDone  = (state_q == S_ACCESS) && timerDone;

  uvepc_timer #(.W(uvepc_pkg::CNT_W)) u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (timerLoad),
    .count (timerCount),
    .done  (timerDone)
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d    = state_q;
    timerLoad  = 1'b0;
    timerCount = '0;
    case (state_q)
      S_IDLE: begin
        if (accept) begin
          state_d    = S_SETUP;
          timerLoad  = 1'b1;
          timerCount = uvepc_pkg::CNT_W'(uvepc_pkg::SETUP_CYC);
        end
      end
      S_SETUP: begin
        if (timerDone) begin
          timerLoad = 1'b1;
          if (isProg) begin
            state_d    = S_PULSE;
            timerCount = uvepc_pkg::CNT_W'(PULSE_CYCLES);
          end else begin
            state_d    = S_ACCESS;
            timerCount = uvepc_pkg::CNT_W'(uvepc_pkg::ACC_CYC);
          end
        end
      end
      S_PULSE, S_ACCESS: begin
        if (timerDone) begin
          state_d    = S_FLOAT;
          timerLoad  = 1'b1;
          timerCount = uvepc_pkg::CNT_W'(uvepc_pkg::DF_CYC);
        end
      end
      S_FLOAT: begin
        if (timerDone) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // Strobe levels wanted in the next state
  wire isProgNext = accept ? (req.cmd == uvepc_pkg::UVEPC_CMD_PROG) : isProg;
  wire isSigNext  = accept ? (req.cmd == uvepc_pkg::UVEPC_CMD_SIG) : isSig;
  wire isReadNext = accept ? (req.cmd == uvepc_pkg::UVEPC_CMD_READ) : isRead;
  wire nxtActive = (state_d == S_PULSE) || (state_d == S_ACCESS) ||
                   (state_d == S_SETUP);
  wire nxtSelN   = !nxtActive; // RULE_05 RULE_11
  wire nxtGateN  = !((state_d == S_ACCESS) && !isProgNext); // RULE_02
  wire nxtPgmN   = !(state_d == S_PULSE); // RULE_08 RULE_10
  wire nxtVpp    = nxtActive && !isReadNext && !isSigNext; // RULE_12
  wire nxtSig    = nxtActive && isSigNext; // RULE_13

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      cur_q   <= '0;
    end else begin
      state_q <= state_d;
      if (accept) begin
        cur_q <= req; // RULE_17
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins.chipSelectN        <= 1'b1;
      pins.outputGateN        <= 1'b1;
      pins.programStrobeN     <= 1'b1;
      pins.vppHigh            <= 1'b0;
      pins.signatureEntryLine <= 1'b0;
      pins.addr               <= uvepc_pkg::ADDR_ZERO;
      dataOut                 <= uvepc_pkg::DATA_ERASED;
      dataOe                  <= 1'b0;
    end else begin
      pins.chipSelectN        <= nxtSelN;
      pins.outputGateN        <= nxtGateN; // RULE_01 RULE_03
      pins.programStrobeN     <= nxtPgmN;
      pins.vppHigh            <= nxtVpp;
      pins.signatureEntryLine <= nxtSig;
      pins.addr               <= accept ? req.addr : pinAddr;
      if (accept && req.cmd == uvepc_pkg::UVEPC_CMD_SIG) begin
        pins.addr <= {{(uvepc_pkg::ADDR_W-1){1'b0}},
                      req.addr[uvepc_pkg::SEL_LINE]}; // RULE_14 RULE_16
      end
      dataOut <= accept ? req.data : cur_q.data; // RULE_09
      // Drive data only while gate is high, the float wait guards contention
      dataOe  <= nxtActive && isProgNext && (state_d != S_ACCESS); // RULE_04
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reqReady    <= 1'b1;
      rspValid    <= 1'b0;
      rspData     <= uvepc_pkg::DATA_ERASED;
      rspMismatch <= 1'b0;
    end else begin
      reqReady <= (state_d == S_IDLE) && !accept;
      rspValid <= readDone || ((state_q == S_PULSE) && timerDone);
      if (readDone) begin
        rspData <= dataIn;
        // Verify: a 0 asked for but read as 1 is a failure
        rspMismatch <= (cur_q.cmd == uvepc_pkg::UVEPC_CMD_VERIFY) &&
                       ((~cur_q.data & dataIn) != '0); // RULE_06 RULE_07
      end else if ((state_q == S_PULSE) && timerDone) begin
        rspMismatch <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  sequence sProgPulse;
    !pins.chipSelectN && !pins.programStrobeN && pins.vppHigh;
  endsequence

  AST_PROG_SUPPLY: assert property (@(posedge clk) disable iff (rst) // RULE_08
    !pins.programStrobeN |-> sProgPulse)
    else $error("strobe low without select or supply");
  AST_NO_GATE_PROG: assert property (@(posedge clk) disable iff (rst) // RULE_10
    !pins.programStrobeN |-> pins.outputGateN)
    else $error("gate low while programming");
  AST_DATA_DRIVE: assert property (@(posedge clk) disable iff (rst) // RULE_09
    !pins.programStrobeN |-> dataOe)
    else $error("data not driven during strobe");
  AST_NO_CONTENTION: assert property (@(posedge clk) disable iff (rst) // RULE_01
    !pins.outputGateN |-> !dataOe)
    else $error("bus contention");
  AST_STABLE: assert property (@(posedge clk) disable iff (rst) // RULE_17
    !pins.programStrobeN && $past(!pins.programStrobeN) |->
    $stable(pins.addr) && $stable(dataOut))
    else $error("address or data moved in strobe");
  AST_SIG_ADDR: assert property (@(posedge clk) disable iff (rst) // RULE_15
    pins.signatureEntryLine |-> (pins.addr >> 1) == '0)
    else $error("signature address lines not low");
  AST_SIG_READ: assert property (@(posedge clk) disable iff (rst) // RULE_13
    pins.signatureEntryLine |-> !pins.vppHigh && pins.programStrobeN)
    else $error("signature not a read");
  AST_VERIFY: assert property (@(posedge clk) disable iff (rst) // RULE_12
    !pins.outputGateN && pins.vppHigh |-> pins.programStrobeN &&
    !pins.chipSelectN)
    else $error("verify levels wrong");
  AST_FLOAT: assert property (@(posedge clk) disable iff (rst) // RULE_04
    $rose(pins.outputGateN) && !isProg |-> !dataOe [*3])
    else $error("drive too soon after gate");
  AST_GATE_SEL: assert property (@(posedge clk) disable iff (rst) // RULE_05
    !pins.outputGateN |-> !pins.chipSelectN)
    else $error("gate low on a deselected device");
  AST_SIG_SEL: assert property (@(posedge clk) disable iff (rst) // RULE_14
    pins.signatureEntryLine |-> !pins.chipSelectN)
    else $error("signature line high while deselected");
endmodule // uvepc_host

// >>> core/uvepc_pkg.sv
// Package of pin bundles, commands and timing constants for the controller
package uvepc_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 250;
  // Times in ns as printed, cycle counts derived
  localparam int T_ACC_NS = 300;
  localparam int T_DF_NS = 105;
  localparam int T_SETUP_NS = 2000;
  localparam int T_PULSE_NS = 1000000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int DF_CYC = (T_DF_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (T_PULSE_NS / 1000) * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_ERASED = 8'hFF;
  localparam int SIG_LINE = 9;
  localparam int SEL_LINE = 0;

  typedef enum logic [1:0] {
    UVEPC_CMD_READ, UVEPC_CMD_PROG, UVEPC_CMD_VERIFY, UVEPC_CMD_SIG
  } uvepc_cmd_t;

  typedef struct packed {
    uvepc_cmd_t          cmd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } uvepc_req_t;

  // Control pins to the memory; all strobes active low
  typedef struct packed {
    logic                chipSelectN;
    logic                outputGateN;
    logic                programStrobeN;
    logic                vppHigh;
    logic                signatureEntryLine;
    logic [ADDR_W-1:0]   addr;
  } uvepc_pins_t;
endpackage

// >>> core/uvepc_timer.sv
// Down counter that gives one-cycle done pulse after a loaded count
`timescale 1ns/1ps
module uvepc_timer #(
  parameter int W = 20
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic         run_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= run_q && (cnt_q == W'(1));
      if (load) begin
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        cnt_q <= cnt_q - W'(1);
        if (cnt_q == W'(1)) begin
          run_q <= 1'b0;
        end
      end
    end
  end
endmodule // uvepc_timer

// >>> tb/tb.sv
// Self-checking bench of the host controller against the memory model
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  uvepc_pkg::uvepc_req_t req = '0;
  logic reqReady, rspValid, rspMismatch, dataOe, memDrive;
  logic [7:0] rspData, dataOut, memOut, busLevel;
  uvepc_pkg::uvepc_pins_t pins;
  int mismatches = 0;
  int check_count = 0;
  logic badProg, sawProg, badSig, sawRead;

  always #2 clk = ~clk;
  assign busLevel = dataOe ? dataOut : memOut;

  uvepc_host #(.PULSE_CYCLES(10)) dut_u (.clk(clk), .rst(rst),
    .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .rspMismatch(rspMismatch),
    .pins(pins), .dataIn(busLevel), .dataOut(dataOut), .dataOe(dataOe));
  uvepc_mem_model mem_u (.pins(pins), .busIn(busLevel), .memOut(memOut),
    .memDrive(memDrive));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check_byte(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(logic got, logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask

  // One whole request, watching the pins until answer and idle again
  task automatic run_op(uvepc_pkg::uvepc_cmd_t cmd, logic [12:0] a,
                        logic [7:0] d);
    int n;
    badProg = 1'b0;
    sawProg = 1'b0;
    badSig = 1'b0;
    sawRead = 1'b0;
    @(negedge clk);
    reqValid = 1'b1;
    req = '{cmd: cmd, addr: a, data: d};
    @(negedge clk);
    reqValid = 1'b0;
    check_bit(reqReady, 1'b0);
    for (n = 0; n < 3000 && rspValid !== 1'b1; n++) begin
      if (pins.programStrobeN === 1'b0) begin
        sawProg = 1'b1;
        if (pins.vppHigh !== 1'b1 || pins.chipSelectN !== 1'b0
            || pins.outputGateN !== 1'b1 || dataOe !== 1'b1
            || dataOut !== d || pins.addr !== a) badProg = 1'b1;
      end
      if (cmd == uvepc_pkg::UVEPC_CMD_SIG && pins.chipSelectN === 1'b0
          && (pins.signatureEntryLine !== 1'b1
              || pins.addr[12:1] !== 12'h000)) badSig = 1'b1;
      if (pins.outputGateN === 1'b0 && dataOe === 1'b1) badProg = 1'b1;
      if (memDrive === 1'b1) sawRead = 1'b1;
      @(negedge clk);
    end
    check_bit(rspValid, 1'b1);
    for (n = 0; n < 200 && reqReady !== 1'b1; n++) @(negedge clk);
    check_bit(reqReady, 1'b1);
  endtask

  task automatic t_reset();
    check_bit(pins.chipSelectN, 1'b1);
    check_bit(pins.programStrobeN, 1'b1);
    check_bit(pins.vppHigh, 1'b0);
    check_bit(dataOe, 1'b0);
    check_bit(reqReady, 1'b1);
  endtask

  task automatic t_read(logic [12:0] a, logic [7:0] exp);
    run_op(uvepc_pkg::UVEPC_CMD_READ, a, 8'h00);
    check_bit(sawRead, 1'b1);
    check_byte(rspData, exp);
  endtask

  task automatic t_prog(logic [12:0] a, logic [7:0] d);
    run_op(uvepc_pkg::UVEPC_CMD_PROG, a, d);
    check_bit(sawProg, 1'b1);
    check_bit(badProg, 1'b0);
    check_bit(sawRead, 1'b0);
    check_bit(rspMismatch, 1'b0);
  endtask

  task automatic t_verify(logic [12:0] a, logic [7:0] d, logic expBad);
    run_op(uvepc_pkg::UVEPC_CMD_VERIFY, a, d);
    check_bit(pins.vppHigh, 1'b0);
    check_bit(rspMismatch, expBad);
  endtask

  task automatic t_sig(logic sel, logic [7:0] exp);
    run_op(uvepc_pkg::UVEPC_CMD_SIG, {12'h000, sel}, 8'h00);
    check_bit(badSig, 1'b0);
    check_byte(rspData, exp);
  endtask

  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_read(13'h0123, 8'hFF);
    t_prog(13'h0123, 8'hA5);
    t_verify(13'h0123, 8'hA5, 1'b0);
    t_prog(13'h0123, 8'hFF);
    t_read(13'h0123, 8'hA5);
    t_prog(13'h0123, 8'h0F);
    t_read(13'h0123, 8'h05);
    t_verify(13'h0123, 8'h00, 1'b1);
    t_read(13'h1FFF, 8'hFF);
    t_sig(1'b0, 8'h5A);
    t_sig(1'b1, 8'hC3);
    report_and_stop();
  end
endmodule // tb

// >>> tb/uvepc_mem_model.sv
// Behavioural memory device model facing the host controller
`timescale 1ns/1ps
module uvepc_mem_model #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] TYPE_ID  = 8'hC3  // Arbitrary value
) (
  // Control pins
  input  wire uvepc_pkg::uvepc_pins_t        pins,
  // Data pins
  input  wire logic [uvepc_pkg::DATA_W-1:0]  busIn,
  output logic [uvepc_pkg::DATA_W-1:0]       memOut,
  output logic                               memDrive
);
  logic [uvepc_pkg::DATA_W-1:0] cells [2**uvepc_pkg::ADDR_W];
  logic [uvepc_pkg::DATA_W-1:0] readVal;
  logic [uvepc_pkg::DATA_W-1:0] lastVal;
  logic                         progOn;

  initial begin
    foreach (cells[i]) cells[i] = uvepc_pkg::DATA_ERASED;
    lastVal = 8'h00;
  end
  assign memDrive = !pins.chipSelectN && !pins.outputGateN
                    && pins.programStrobeN;
  assign readVal = pins.signatureEntryLine
                   ? (pins.addr[0] ? TYPE_ID : MAKER_ID)
                   : cells[pins.addr];
  // Released bus shows inverse of last value, never a stale match
  always @(readVal or memDrive) if (memDrive) lastVal = readVal;
  assign memOut = memDrive ? readVal : ~lastVal;
  assign progOn = pins.vppHigh === 1'b1 && pins.chipSelectN === 1'b0
                  && pins.programStrobeN === 1'b0;
  // Cells only lose ones; written at strobe fall, data long steady
  always @(posedge progOn)
    cells[pins.addr] = cells[pins.addr] & busIn;
endmodule // uvepc_mem_model
